// File: octal_bus_transceiver_register.sv
// octal bus transceiver with a capture register per side, clocked by sys_clk
// assumes every pin input is asynchronous; capture clocks are sampled pins
`timescale 1ns/1ps
module octal_bus_transceiver_register #(
   parameter int DATA_W = xcvr_pkg::DATA_W,
   parameter int LOG_DEPTH = xcvr_pkg::LOG_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // port a, split into three signals
   input wire logic [DATA_W-1:0] port_a_in,
   output logic [DATA_W-1:0] port_a_out,
   output logic port_a_oe_n,
   // port b, split into three signals
   input wire logic [DATA_W-1:0] port_b_in,
   output logic [DATA_W-1:0] port_b_out,
   output logic port_b_oe_n,
   // control pins
   input wire logic output_enable_n,
   input wire logic direction,
   input wire logic b_output_source_select,
   input wire logic a_output_source_select,
   input wire logic a_capture_clock,
   input wire logic b_capture_clock,
   // stored register contents
   output logic [DATA_W-1:0] a_register,
   output logic [DATA_W-1:0] b_register,
   // capture log stream
   output logic log_valid,
   input wire logic log_ready,
   output logic [xcvr_pkg::LOG_W-1:0] log_data,
   output logic log_in_ready,
   output logic log_overflow
);
   logic [xcvr_pkg::PIN_W-1:0] pins_async;
   logic [xcvr_pkg::PIN_W-1:0] pins;
   logic [DATA_W-1:0] live_a;
   logic [DATA_W-1:0] live_b;
   logic cap_a_prev;
   logic cap_b_prev;
   logic cap_a_rise;
   logic cap_b_rise;
   logic drive_a;
   logic drive_b;
   logic [DATA_W-1:0] next_a_register;
   logic [DATA_W-1:0] next_b_register;
   logic [DATA_W-1:0] next_port_a_out;
   logic [DATA_W-1:0] next_port_b_out;
   logic next_port_a_oe_n;
   logic next_port_b_oe_n;
   logic next_log_overflow;
   logic [xcvr_pkg::LOG_W-1:0] log_word;
   logic log_push;

   // all pins cross as one bundle so data and capture clocks stay aligned
   assign pins_async = {a_output_source_select, b_output_source_select, direction,
                        output_enable_n, b_capture_clock, a_capture_clock,
                        port_b_in, port_a_in};

   pin_sync #(
      .W(xcvr_pkg::PIN_W),
      .RESET_VAL(xcvr_pkg::PIN_RESET)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(pins_async),
      .sync_out(pins)
   );

   // live port values as seen at the pins, including our own driven value
   assign live_a = pins[xcvr_pkg::PIN_A_LSB +: DATA_W];
   assign live_b = pins[xcvr_pkg::PIN_B_LSB +: DATA_W];

   // edge detect on the synchronised capture clocks; pulses shorter than one sys_clk period may be missed
   assign cap_a_rise = pins[xcvr_pkg::PIN_CAP_A] && !cap_a_prev;
   assign cap_b_rise = pins[xcvr_pkg::PIN_CAP_B] && !cap_b_prev;

   // direction decode: the two drive terms are exclusive by construction
   assign drive_b = !pins[xcvr_pkg::PIN_EN_N] && pins[xcvr_pkg::PIN_DIR];
   assign drive_a = !pins[xcvr_pkg::PIN_EN_N] && !pins[xcvr_pkg::PIN_DIR];

   // capture registers ignore enable and direction entirely
   always_comb begin
      next_a_register = a_register;
      next_b_register = b_register;
      if (cap_a_rise) begin
         next_a_register = live_a;
      end
      if (cap_b_rise) begin
         next_b_register = live_b;
      end
   end

   // output muxes; a disabled side is floated and its data held low
   always_comb begin
      next_port_b_oe_n = !drive_b;
      next_port_a_oe_n = !drive_a;
      next_port_b_out = '0;
      next_port_a_out = '0;
      if (drive_b) begin
         next_port_b_out = pins[xcvr_pkg::PIN_SEL_B] ? a_register : live_a;
      end
      if (drive_a) begin
         next_port_a_out = pins[xcvr_pkg::PIN_SEL_A] ? b_register : live_b;
      end
   end

   // capture log: one word per cycle with any capture edge
   assign log_word = {cap_a_rise, cap_b_rise, live_a, live_b};
   assign log_push = cap_a_rise || cap_b_rise;

   // a full log never blocks capture; the loss is flagged sticky instead
   always_comb begin
      next_log_overflow = log_overflow || (log_push && !log_in_ready);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cap_a_prev <= 1'b0;
         cap_b_prev <= 1'b0;
         a_register <= xcvr_pkg::REG_RESET;
         b_register <= xcvr_pkg::REG_RESET;
         port_a_out <= '0;
         port_b_out <= '0;
         port_a_oe_n <= 1'b1;
         port_b_oe_n <= 1'b1;
         log_overflow <= 1'b0;
      end else begin
         cap_a_prev <= pins[xcvr_pkg::PIN_CAP_A];
         cap_b_prev <= pins[xcvr_pkg::PIN_CAP_B];
         a_register <= next_a_register;
         b_register <= next_b_register;
         port_a_out <= next_port_a_out;
         port_b_out <= next_port_b_out;
         port_a_oe_n <= next_port_a_oe_n;
         port_b_oe_n <= next_port_b_oe_n;
         log_overflow <= next_log_overflow;
      end
   end

   log_fifo #(
      .W(xcvr_pkg::LOG_W),
      .DEPTH(LOG_DEPTH)
   ) u_log_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(log_push),
      .in_ready(log_in_ready),
      .in_data(log_word),
      .out_valid(log_valid),
      .out_ready(log_ready),
      .out_data(log_data)
   );
endmodule : octal_bus_transceiver_register

// File: xcvr_pkg.sv
// constants shared by the bus transceiver and its capture log
// assumes nothing beyond a single system clock domain
package xcvr_pkg;
   localparam int DATA_W = 8;
   localparam int LOG_DEPTH = 16;
   // capture log word: {a_captured, b_captured, port_a, port_b}
   localparam int LOG_W = 2 * DATA_W + 2;
   localparam int LOG_A_FLAG = LOG_W - 1;
   localparam int LOG_B_FLAG = LOG_W - 2;
   // synchronised pin bundle layout
   localparam int PIN_A_LSB = 0;
   localparam int PIN_B_LSB = DATA_W;
   localparam int PIN_CAP_A = 2 * DATA_W;
   localparam int PIN_CAP_B = 2 * DATA_W + 1;
   localparam int PIN_EN_N = 2 * DATA_W + 2;
   localparam int PIN_DIR = 2 * DATA_W + 3;
   localparam int PIN_SEL_B = 2 * DATA_W + 4;
   localparam int PIN_SEL_A = 2 * DATA_W + 5;
   localparam int PIN_W = 2 * DATA_W + 6;
   // reset value of the pin bundle: enable held inactive (high)
   localparam logic [PIN_W-1:0] PIN_RESET = 22'h04_0000;
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
endpackage : xcvr_pkg

// File: pin_sync.sv
// two-flop synchroniser for a bundle of asynchronous pin inputs
// assumes each bit is an independent level; words are re-aligned by the user
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // pins in, synchronised out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync_out;

   // first stage feeds only the second stage
   always_comb begin
      next_meta = async_in;
      next_sync_out = meta;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta <= next_meta;
         sync_out <= next_sync_out;
      end
   end
endmodule : pin_sync

// File: log_fifo.sv
// capture log fifo with registered read data and valid/ready on both sides
// assumes the drain side may stall; in_ready falls honestly when full
`timescale 1ns/1ps
module log_fifo #(
   parameter int W = 18,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] cnt;
   logic [AW-1:0] next_wptr;
   logic [AW-1:0] next_rptr;
   logic [AW:0] next_cnt;
   logic next_out_valid;
   logic [W-1:0] next_out_data;
   logic push;
   logic pop;

   // pointer and count arithmetic; the output register is an extra slot
   always_comb begin
      in_ready = (cnt != (AW+1)'(DEPTH));
      push = in_valid && in_ready;
      pop = (cnt != '0) && (!out_valid || out_ready);
      next_wptr = push ? wptr + 1'b1 : wptr;
      next_rptr = pop ? rptr + 1'b1 : rptr;
      next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
      next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
      next_out_data = pop ? mem[rptr] : out_data;
   end

   // storage array needs no reset
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wptr <= '0;
         rptr <= '0;
         cnt <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         cnt <= next_cnt;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
   end
endmodule : log_fifo

// File: xcvr_bus_model.sv
// far side of the transceiver: two parallel buses with their own data sources
// assumes the bench sets the undriven-bus values; no pull resistors on either bus
`timescale 1ns/1ps
module xcvr_bus_model (
   // values the outside parties offer
   input wire logic [7:0] a_val,
   input wire logic [7:0] b_val,
   // device side of the split pins
   input wire logic [7:0] port_a_out,
   input wire logic port_a_oe_n,
   input wire logic [7:0] port_b_out,
   input wire logic port_b_oe_n,
   // resolved bus levels
   output logic [7:0] port_a_in,
   output logic [7:0] port_b_in
);
   // a party backs off whenever the device drives its bus, so no contention
   assign port_a_in = port_a_oe_n ? a_val : port_a_out;
   assign port_b_in = port_b_oe_n ? b_val : port_b_out;
endmodule : xcvr_bus_model

// File: octal_bus_transceiver_register_sva.sv
// pin-level assertions for the transceiver
// assumes one sys_clk domain; windows allow two or three cycles of sync delay
`timescale 1ns/1ps
module octal_bus_transceiver_register_sva (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // ports
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_a_out,
   input wire logic port_a_oe_n,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] port_b_out,
   input wire logic port_b_oe_n,
   // controls and stored words
   input wire logic output_enable_n,
   input wire logic direction,
   input wire logic b_output_source_select,
   input wire logic a_output_source_select,
   input wire logic a_capture_clock,
   input wire logic b_capture_clock,
   input wire logic [7:0] a_register
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // direction decodes
   wire to_b = !output_enable_n && direction;
   wire to_a = !output_enable_n && !direction;
   one_driver_a: assert property (port_a_oe_n || port_b_oe_n)
      else $error("both ports driven");
   isolate_off_a: assert property (output_enable_n [*2] |-> ##2 port_a_oe_n && port_b_oe_n)
      else $error("port driven while disabled");
   drive_b_a: assert property (to_b [*2] |-> ##2 !port_b_oe_n && port_a_oe_n)
      else $error("port b not driven");
   drive_a_a: assert property (to_a [*2] |-> ##2 !port_a_oe_n && port_b_oe_n)
      else $error("port a not driven");
   live_b_a: assert property ((to_b && !b_output_source_select && $stable(port_a_in)) [*3]
      |-> ##2 port_b_out == $past(port_a_in, 2)) else $error("live a not on b");
   stored_b_a: assert property ((to_b && b_output_source_select && !a_capture_clock) [*4]
      |-> ##2 port_b_out == $past(a_register, 2)) else $error("stored a not on b");
   live_a_a: assert property ((to_a && !a_output_source_select && $stable(port_b_in)) [*3]
      |-> ##2 port_a_out == $past(port_b_in, 2)) else $error("live b not on a");
   capture_a_a: assert property ($rose(a_capture_clock) ##1
      (a_capture_clock && $stable(port_a_in)) [*2] |-> ##2 a_register == $past(port_a_in, 2))
      else $error("a capture missed");
endmodule : octal_bus_transceiver_register_sva

// File: octal_bus_transceiver_register_test.sv
// self-checking bench for the transceiver, its capture log and bus model
// assumes the design's three-cycle pin latency; inputs change on falling edges
`timescale 1ns/1ps
module octal_bus_transceiver_register_test;
   logic sys_clk, rst, output_enable_n, direction, b_output_source_select;
   logic a_output_source_select, a_capture_clock, b_capture_clock, log_ready;
   logic [7:0] a_val, b_val, port_a_in, port_b_in, port_a_out, port_b_out, a_register, b_register;
   logic port_a_oe_n, port_b_oe_n, log_valid, log_in_ready, log_overflow;
   logic [17:0] log_data;
   int miscompares = 0, n_tests = 0, cycles = 0, n;
   octal_bus_transceiver_register i_dut (.sys_clk, .rst, .port_a_in, .port_a_out, .port_a_oe_n,
      .port_b_in, .port_b_out, .port_b_oe_n, .output_enable_n, .direction, .b_output_source_select,
      .a_output_source_select, .a_capture_clock, .b_capture_clock, .a_register, .b_register,
      .log_valid, .log_ready, .log_data, .log_in_ready, .log_overflow);
   xcvr_bus_model i_bus (.a_val, .b_val, .port_a_out, .port_a_oe_n, .port_b_out, .port_b_oe_n,
      .port_a_in, .port_b_in);
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wt(input int c);
      repeat (c) @(negedge sys_clk);
   endtask : wt
   // controls must stand well past the sync delay before judging
   task automatic ctl(input logic e, input logic d, input logic sb, input logic sa);
      {output_enable_n, direction, b_output_source_select, a_output_source_select} = {e, d, sb, sa};
      wt(6);
   endtask : ctl
   // capture pulses are held four cycles so the sampler never misses them
   task automatic cap(input logic ca, input logic cb);
      {a_capture_clock, b_capture_clock} = {ca, cb};
      wt(4);
      {a_capture_clock, b_capture_clock} = 2'b00;
      wt(4);
   endtask : cap
   task automatic t_isolation;
      ctl(1, 1, 1, 1);
      {a_val, b_val} = 16'h5aa5;
      wt(3);
      cap(1, 1);
      chk("a_register", 8'h5a, a_register);
      chk("b_register", 8'ha5, b_register);
      chk("oe_n", 8'h03, {6'h00, port_a_oe_n, port_b_oe_n});
      a_val = 8'h11;
      wt(3);
      cap(1, 0);
      wt(10);
      chk("a_register", 8'h11, a_register);
      chk("b_register", 8'ha5, b_register);
   endtask : t_isolation
   task automatic t_a_to_b;
      a_val = 8'h3c;
      ctl(0, 1, 0, 0);
      chk("port_b_out", 8'h3c, port_b_out);
      chk("oe_n", 8'h02, {6'h00, port_a_oe_n, port_b_oe_n});
      ctl(0, 1, 1, 0);
      chk("port_b_out", 8'h11, port_b_out);
      cap(1, 1);
      chk("b_register", 8'h11, b_register);
      chk("port_b_out", 8'h3c, port_b_out);
   endtask : t_a_to_b
   task automatic t_b_to_a;
      b_val = 8'hc3;
      ctl(0, 0, 0, 0);
      chk("port_a_out", 8'hc3, port_a_out);
      chk("oe_n", 8'h01, {6'h00, port_a_oe_n, port_b_oe_n});
      ctl(0, 0, 0, 1);
      chk("port_a_out", 8'h11, port_a_out);
   endtask : t_b_to_a
   // 3 words logged so far; 16 more overrun a log that holds 17
   task automatic t_log;
      repeat (16) cap(0, 1);
      chk("log_in_ready", 8'h00, {7'h00, log_in_ready});
      chk("log_overflow", 8'h01, {7'h00, log_overflow});
      // oldest word waits in the output register: the isolated store of both sides
      chk("log flags", 8'h03, {6'h00, log_data[17:16]});
      chk("log port_a", 8'h5a, log_data[15:8]);
      chk("log port_b", 8'ha5, log_data[7:0]);
      log_ready = 1;
      // the word already waiting leaves at the next edge, so it counts too
      n = int'(log_valid);
      repeat (40) begin
         @(negedge sys_clk);
         n += int'(log_valid);
      end
      chk("drained", 8'h11, 8'(n));
   endtask : t_log
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // clock
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // main sequence
   initial begin
      {rst, output_enable_n, direction, b_output_source_select, a_output_source_select} = 5'h18;
      {a_capture_clock, b_capture_clock, log_ready, a_val, b_val} = 19'h0_0000;
      wt(12);
      rst = 0;
      wt(2);
      t_isolation();
      t_a_to_b();
      t_b_to_a();
      t_log();
      tally_and_finish();
   end
endmodule : octal_bus_transceiver_register_test
bind octal_bus_transceiver_register octal_bus_transceiver_register_sva i_sva (.sys_clk, .rst,
   .port_a_in, .port_a_out, .port_a_oe_n, .port_b_in, .port_b_out, .port_b_oe_n, .output_enable_n,
   .direction, .b_output_source_select, .a_output_source_select, .a_capture_clock,
   .b_capture_clock, .a_register);
